// [core/pmr_cfg.svh]
// Constants for the power-management support register slice.
// How it works
// - Trigger configuration bit 3 enables the second serial port interrupt as reload trigger.
// - Any enabled trigger before expiry reloads the countdown with the programmed timeout value.
// - Countdown reaching zero drives the active-low timeout output low.
// - Timeout status resets to 01h on reset and on device activation.
// - Status bit 0 is read-only and mirrors the timeout output level.
// - Status bit follows the timeout output even when the pin is general-purpose.
// - Event and timer base low bytes keep bits 1:0 zero and read-only.
// - Control base low byte keeps bit 0 zero and read-only.
// - General-purpose status base low byte keeps bits 3:0 zero and read-only.
// - Each base high byte is fully writable and resets to 00h.
// - Support register resets to 00h.
// - Support bit 0 sets on sleep-enable write, clears on software write of 1.
// - Support bit 1 with sleep flag set asserts the interrupt-request pin.
// - Support bit 2 sets on global-lock release write, clears on write of 1.
// - With support bit 3 clear the global-lock flag leaves the pin alone.
// - Writing 1 to support bit 4 pulses the global-lock status set request.
// - Support bit 5 sets on command-register write, clears on write of 1.
// - Support bit 6 with command flag set asserts the interrupt-request pin.
// - Support bit 7 masks all event bits except wake and clock-alarm bits.
// - Timer status and enable bits follow timer clock enable, not the mask.
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH
`define PMR_ADDR_TRIG 4'h0
`define PMR_ADDR_PERIOD 4'h1
`define PMR_ADDR_STATUS 4'h2
`define PMR_ADDR_EVL 4'h3
`define PMR_ADDR_EVH 4'h4
`define PMR_ADDR_TML 4'h5
`define PMR_ADDR_TMH 4'h6
`define PMR_ADDR_CTL 4'h7
`define PMR_ADDR_CTH 4'h8
`define PMR_ADDR_GPL 4'h9
`define PMR_ADDR_GPH 4'ha
`define PMR_ADDR_SUP 4'hb
`define PMR_ADDR_CFG 4'hc
`define PMR_EV_RO_MASK 8'h03
`define PMR_CT_RO_MASK 8'h01
`define PMR_GP_RO_MASK 8'h0f
`define PMR_TRIG_MASK 8'h0f
`define PMR_STATUS_RESET 8'h01
`define PMR_ZERO8 8'h00
`define PMR_COUNT_LAST 8'h01
`define PMR_SUP_SLP 0
`define PMR_SUP_SLP_EN 1
`define PMR_SUP_GL 2
`define PMR_SUP_GL_EN 3
`define PMR_SUP_BIOS_REL 4
`define PMR_SUP_SMI 5
`define PMR_SUP_SMI_EN 6
`define PMR_SUP_MASK 7
`define PMR_SUP_W1C 8'h25
`define PMR_SUP_RW 8'hca
`define PMR_TRIG_UART2 3
`define PMR_CFG_GPIO_BIT 6
`define PMR_MINUTE_S 60
`define PMR_CLK_HZ 125000000
`define PMR_TICKS_PER_MIN (64'(`PMR_MINUTE_S) * 64'(`PMR_CLK_HZ))
`endif

// [core/pmr_pkg.sv]
// Types for the power-management support register slice.
package pmr_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmr_bus_type;

    typedef struct packed {
        logic kbc;
        logic mouse;
        logic uart1;
        logic uart2;
    } pmr_irq_type;

    typedef struct packed {
        logic [7:0] trig_cfg;
        logic [7:0] timeout_val;
        logic [7:0] count;
        logic [33:0] tick;
        logic out_n;
        logic [7:0] ev_lo;
        logic [7:0] ev_hi;
        logic [7:0] tm_lo;
        logic [7:0] tm_hi;
        logic [7:0] ct_lo;
        logic [7:0] ct_hi;
        logic [7:0] gp_lo;
        logic [7:0] gp_hi;
        logic [7:0] support;
        logic gpio_sel;
        logic gl_set_pulse;
        logic [7:0] rdata;
        logic [3:0] irq_s1;
        logic [3:0] irq_s2;
    } pmr_state_type;
endpackage : pmr_pkg

// [core/pmr_regs.sv]
// Timeout timer, fixed-block base addresses and support flags.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pmr_cfg.svh"
`default_nettype none
module pmr_regs
    import pmr_pkg::*;
#(
    parameter logic [33:0] TICKS_PER_MIN = 34'(`PMR_TICKS_PER_MIN)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic pm_activate,
    input wire pmr_bus_type bus,
    output logic [7:0] rdata,
    input wire pmr_irq_type irq_in,
    input wire logic sleep_en_written,
    input wire logic gl_release_written,
    input wire logic smi_cmd_written,
    input wire logic timer_clk_en,
    output logic timeout_out_n,
    output logic shared_gp_sel,
    output logic irq_req,
    output logic gl_status_set,
    output logic ev_mask,
    output logic tmr_bits_en,
    output logic [15:0] event_base,
    output logic [15:0] timer_base,
    output logic [15:0] control_base,
    output logic [15:0] gp_base
);
    pmr_state_type state;
    pmr_state_type next_state;
    logic [3:0] irq_vec;
    logic trigger;
    logic wr_sup;

    assign irq_vec = {irq_in.uart2, irq_in.uart1, irq_in.mouse, irq_in.kbc};
    assign wr_sup = bus.wr && bus.addr == `PMR_ADDR_SUP;

    always_comb begin
        next_state = state;
        next_state.irq_s1 = irq_vec;
        next_state.irq_s2 = state.irq_s1;
        next_state.gl_set_pulse = 1'b0;
        trigger = |(state.irq_s2 & state.trig_cfg[`PMR_TRIG_UART2:0]);
        // The timer is live only while a non-zero period is programmed.
        if (state.timeout_val != `PMR_ZERO8 && state.out_n) begin
            if (trigger) begin
                next_state.count = state.timeout_val;
                next_state.tick = '0;
            end else if (state.tick == TICKS_PER_MIN - 34'h1) begin
                next_state.tick = '0;
                next_state.count = state.count - 8'h01;
                if (state.count == `PMR_COUNT_LAST) begin
                    next_state.out_n = 1'b0;
                end
            end else begin
                next_state.tick = state.tick + 34'h1;
            end
        end
        if (bus.wr) begin
            case (bus.addr)
                `PMR_ADDR_TRIG: next_state.trig_cfg = bus.wdata & `PMR_TRIG_MASK;
                `PMR_ADDR_PERIOD: begin
                    next_state.timeout_val = bus.wdata;
                    next_state.count = bus.wdata;
                    next_state.tick = '0;
                    next_state.out_n = 1'b1;
                end
                `PMR_ADDR_EVL: next_state.ev_lo = bus.wdata & ~`PMR_EV_RO_MASK;
                `PMR_ADDR_EVH: next_state.ev_hi = bus.wdata;
                `PMR_ADDR_TML: next_state.tm_lo = bus.wdata & ~`PMR_EV_RO_MASK;
                `PMR_ADDR_TMH: next_state.tm_hi = bus.wdata;
                `PMR_ADDR_CTL: next_state.ct_lo = bus.wdata & ~`PMR_CT_RO_MASK;
                `PMR_ADDR_CTH: next_state.ct_hi = bus.wdata;
                `PMR_ADDR_GPL: next_state.gp_lo = bus.wdata & ~`PMR_GP_RO_MASK;
                `PMR_ADDR_GPH: next_state.gp_hi = bus.wdata;
                `PMR_ADDR_SUP: begin
                    // Flag bits clear on a written 1; enable bits take the written value.
                    next_state.support = (state.support & `PMR_SUP_W1C & ~bus.wdata)
                        | (bus.wdata & `PMR_SUP_RW);
                    next_state.support[`PMR_SUP_BIOS_REL] = 1'b0;
                    next_state.gl_set_pulse = bus.wdata[`PMR_SUP_BIOS_REL];
                end
                `PMR_ADDR_CFG: next_state.gpio_sel = bus.wdata[`PMR_CFG_GPIO_BIT];
                default: ;
            endcase
        end
        // Hardware sets are applied last so that an event never loses to a clear.
        if (sleep_en_written) begin
            next_state.support[`PMR_SUP_SLP] = 1'b1;
        end
        if (gl_release_written) begin
            next_state.support[`PMR_SUP_GL] = 1'b1;
        end
        if (smi_cmd_written) begin
            next_state.support[`PMR_SUP_SMI] = 1'b1;
        end
        if (pm_activate) begin
            next_state.trig_cfg = `PMR_ZERO8;
            next_state.timeout_val = `PMR_ZERO8;
            next_state.count = `PMR_ZERO8;
            next_state.tick = '0;
            next_state.out_n = 1'b1;
        end
        next_state.rdata = `PMR_ZERO8;
        if (bus.rd) begin
            case (bus.addr)
                `PMR_ADDR_TRIG: next_state.rdata = state.trig_cfg;
                `PMR_ADDR_PERIOD: next_state.rdata = state.timeout_val;
                `PMR_ADDR_STATUS: next_state.rdata = {7'h00, state.out_n};
                `PMR_ADDR_EVL: next_state.rdata = state.ev_lo;
                `PMR_ADDR_EVH: next_state.rdata = state.ev_hi;
                `PMR_ADDR_TML: next_state.rdata = state.tm_lo;
                `PMR_ADDR_TMH: next_state.rdata = state.tm_hi;
                `PMR_ADDR_CTL: next_state.rdata = state.ct_lo;
                `PMR_ADDR_CTH: next_state.rdata = state.ct_hi;
                `PMR_ADDR_GPL: next_state.rdata = state.gp_lo;
                `PMR_ADDR_GPH: next_state.rdata = state.gp_hi;
                `PMR_ADDR_SUP: next_state.rdata = state.support;
                `PMR_ADDR_CFG: next_state.rdata = {1'b0, state.gpio_sel, 6'h00};
                default: next_state.rdata = `PMR_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
            state.out_n <= 1'b1;
            state.support <= `PMR_ZERO8;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign timeout_out_n = state.out_n;
    assign shared_gp_sel = state.gpio_sel;
    assign gl_status_set = state.gl_set_pulse;
    assign ev_mask = state.support[`PMR_SUP_MASK];
    assign tmr_bits_en = timer_clk_en;
    assign irq_req = (state.support[`PMR_SUP_SLP_EN] & state.support[`PMR_SUP_SLP])
        | (state.support[`PMR_SUP_GL_EN] & state.support[`PMR_SUP_GL])
        | (state.support[`PMR_SUP_SMI_EN] & state.support[`PMR_SUP_SMI]);
    assign event_base = {state.ev_hi, state.ev_lo};
    assign timer_base = {state.tm_hi, state.tm_lo};
    assign control_base = {state.ct_hi, state.ct_lo};
    assign gp_base = {state.gp_hi, state.gp_lo};

    a_status_reset: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> state.out_n == 1'b1) else $error("status not 1 after reset");
    a_status_mirror: assert property (@(posedge clk) disable iff (!resetn)
        bus.rd && bus.addr == `PMR_ADDR_STATUS && clk_en |=> rdata[0] == $past(timeout_out_n))
        else $error("status bit does not mirror output");
    a_ev_align: assert property (@(posedge clk) disable iff (!resetn)
        (event_base[1:0] == 2'b00) && (timer_base[1:0] == 2'b00))
        else $error("event or timer base misaligned");
    a_ct_align: assert property (@(posedge clk) disable iff (!resetn)
        control_base[0] == 1'b0) else $error("control base odd");
    a_gp_align: assert property (@(posedge clk) disable iff (!resetn)
        gp_base[3:0] == 4'h0) else $error("gp base misaligned");
    a_slp_sticky: assert property (@(posedge clk) disable iff (!resetn)
        sleep_en_written && clk_en |=> state.support[`PMR_SUP_SLP] == 1'b1)
        else $error("sleep flag not set");
    a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
        wr_sup && clk_en && bus.wdata[`PMR_SUP_SLP] && !sleep_en_written
        |=> state.support[`PMR_SUP_SLP] == 1'b0)
        else $error("sleep flag not cleared by a written one");
    a_gl_sticky: assert property (@(posedge clk) disable iff (!resetn)
        gl_release_written && clk_en |=> state.support[`PMR_SUP_GL] == 1'b1)
        else $error("global lock flag not set");
    a_smi_sticky: assert property (@(posedge clk) disable iff (!resetn)
        smi_cmd_written && clk_en |=> state.support[`PMR_SUP_SMI] == 1'b1)
        else $error("command flag not set");
    a_slp_en: assert property (@(posedge clk) disable iff (!resetn)
        state.support[`PMR_SUP_SLP_EN] && state.support[`PMR_SUP_SLP] |-> irq_req)
        else $error("sleep request missing");
    a_gl_gate: assert property (@(posedge clk) disable iff (!resetn)
        !state.support[`PMR_SUP_GL_EN] |-> irq_req == ((state.support[`PMR_SUP_SLP_EN]
            && state.support[`PMR_SUP_SLP]) || (state.support[`PMR_SUP_SMI_EN]
            && state.support[`PMR_SUP_SMI])))
        else $error("global lock flag reached the request without enable");
    a_gl_en: assert property (@(posedge clk) disable iff (!resetn)
        state.support[`PMR_SUP_GL_EN] && state.support[`PMR_SUP_GL] |-> irq_req)
        else $error("global lock request missing");
    a_gl_release: assert property (@(posedge clk) disable iff (!resetn)
        wr_sup && bus.wdata[`PMR_SUP_BIOS_REL] && clk_en |=> gl_status_set)
        else $error("global lock release pulse missing");
    a_gl_single: assert property (@(posedge clk) disable iff (!resetn)
        gl_status_set && clk_en && !(wr_sup && bus.wdata[`PMR_SUP_BIOS_REL])
        |=> !gl_status_set)
        else $error("global lock release pulse too long");
    a_irq_or: assert property (@(posedge clk) disable iff (!resetn)
        state.support[`PMR_SUP_SMI_EN] && state.support[`PMR_SUP_SMI] |-> irq_req)
        else $error("command request missing");
    a_trig_reload: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && trigger && state.out_n && state.timeout_val != `PMR_ZERO8 && !bus.wr
            && !pm_activate |=> state.count == $past(state.timeout_val))
        else $error("trigger did not reload the countdown");
    a_count_expiry: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && !trigger && state.out_n && state.timeout_val != `PMR_ZERO8
            && state.count == `PMR_COUNT_LAST && state.tick == TICKS_PER_MIN - 34'h1
            && !bus.wr && !pm_activate |=> !timeout_out_n)
        else $error("countdown expiry did not assert the timeout output");
    c_reload: cover property (@(posedge clk) disable iff (!resetn)
        trigger && state.out_n && state.timeout_val != `PMR_ZERO8);
    c_timeout: cover property (@(posedge clk) disable iff (!resetn) $fell(timeout_out_n));
    c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq_req));
    c_release: cover property (@(posedge clk) disable iff (!resetn) gl_status_set);
endmodule : pmr_regs
`default_nettype wire

// [tb/pmr_regs_test.sv]
// Self-checking bench for the power-management support register slice.
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_test import pmr_pkg::*; ;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic pm_activate = 1'b0;
    logic timer_clk_en = 1'b0;
    logic [2:0] ev = 3'h0;
    pmr_bus_type bus = '0;
    pmr_irq_type irq_in = '0;
    logic [7:0] rdata;
    logic timeout_out_n, shared_gp_sel, irq_req, gl_status_set, ev_mask, tmr_bits_en;
    logic [15:0] event_base, timer_base, control_base, gp_base;
    int err_count = 0;
    int checks_done = 0;
    logic [7:0] bexp [8] = '{8'hfc, 8'hff, 8'hfc, 8'hff, 8'hfe, 8'hff, 8'hf0, 8'hff};
    logic [7:0] en [3] = '{8'h02, 8'h08, 8'h40};

    always #4 clk = ~clk;

    // A short minute keeps the countdown scenarios within a few hundred cycles.
    pmr_regs #(.TICKS_PER_MIN(34'ha)) u_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .pm_activate(pm_activate), .bus(bus), .rdata(rdata), .irq_in(irq_in),
        .sleep_en_written(ev[0]), .gl_release_written(ev[1]), .smi_cmd_written(ev[2]),
        .timer_clk_en(timer_clk_en), .timeout_out_n(timeout_out_n),
        .shared_gp_sel(shared_gp_sel), .irq_req(irq_req), .gl_status_set(gl_status_set),
        .ev_mask(ev_mask), .tmr_bits_en(tmr_bits_en), .event_base(event_base),
        .timer_base(timer_base), .control_base(control_base), .gp_base(gp_base));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(16'(rdata), 16'(exp));
    endtask : rd

    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
        #1;
    endtask : pulse

    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h2, 8'h01);
        chk(16'(tmr_bits_en), 16'h0);
        for (int i = 0; i < 9; i++) rd(4'(i + 3), 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(4'(i + 3), 8'hff);
            rd(4'(i + 3), bexp[i]);
        end
        chk(event_base, 16'hfffc);
        chk(timer_base, 16'hfffc);
        chk(control_base, 16'hfffe);
        chk(gp_base, 16'hfff0);
        // With the clock enable low a write must not land.
        @(posedge clk);
        clk_en <= 1'b0;
        wr(4'h4, 8'h5a);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(4'h4, 8'hff);
        wr(4'hb, 8'h25);
        pulse(3'h7);
        chk(16'(irq_req), 16'h0);
        for (int k = 0; k < 3; k++) begin
            wr(4'hb, en[k]);
            chk(16'(irq_req), 16'h1);
            rd(4'hb, 8'h25 | en[k]);
        end
        wr(4'hb, 8'h4b);
        chk(16'(irq_req), 16'h1);
        wr(4'hb, 8'h4e);
        chk(16'(irq_req), 16'h1);
        wr(4'hb, 8'h6a);
        chk(16'(irq_req), 16'h0);
        rd(4'hb, 8'h4a);
        wr(4'hb, 8'h10);
        chk(16'(gl_status_set), 16'h1);
        @(posedge clk);
        #1 chk(16'(gl_status_set), 16'h0);
        rd(4'hb, 8'h00);
        wr(4'hb, 8'h80);
        chk(16'(ev_mask), 16'h1);
        @(posedge clk);
        timer_clk_en <= 1'b1;
        @(posedge clk);
        #1 chk(16'(tmr_bits_en), 16'h1);
        wr(4'h0, 8'h08);
        rd(4'h0, 8'h08);
        wr(4'h1, 8'h02);
        // Trigger gaps stay well below the two-minute period, so no expiry may show.
        repeat (8) begin
            @(posedge clk);
            irq_in <= 4'h1;
            repeat (3) @(posedge clk);
            irq_in <= 4'h0;
            repeat (5) @(posedge clk);
            #1 chk(16'(timeout_out_n), 16'h1);
        end
        repeat (50) @(posedge clk);
        #1 chk(16'(timeout_out_n), 16'h0);
        rd(4'h2, 8'h00);
        wr(4'hc, 8'h40);
        chk(16'(shared_gp_sel), 16'h1);
        rd(4'h2, 8'h00);
        @(posedge clk);
        pm_activate <= 1'b1;
        @(posedge clk);
        pm_activate <= 1'b0;
        @(posedge clk);
        #1 chk(16'(timeout_out_n), 16'h1);
        rd(4'h2, 8'h01);
        rd(4'h0, 8'h00);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(4'ha, 8'h00);
        rd(4'h2, 8'h01);
        rd(4'hb, 8'h00);
        stop_test();
    end
endmodule : pmr_regs_test
`default_nettype wire
